/* File: hdl/iex_expander.v */
// Sixteen-port I/O expander with change alert, reached as a two-wire bus slave.
// Assumes the bus master makes the serial clock; all pins are asynchronous to mclk.
// How it works
// [RULE1] Abort input forces serial interface idle
// [RULE2] Abort leaves alert and flags alone
// [RULE3] Input ports compared against last-access reference
// [RULE4] Alert goes low, latched until group read
// [RULE5] Output-configured pins never raise alert
// [RULE6] Separate change flag per eight-bit group
// [RULE7] Mask bit one disables port alert
// [RULE8] Direction bit one input, zero output
// [RULE9] Software masks pin before making it input
// [RULE10] Start is data fall, clock high
// [RULE11] Stop is data rise, clock high
// [RULE12] Data sampled on clock rise, stable high
// [RULE13] Master frames start, address, bytes, stop
// [RULE14] Address 10110 plus two select inputs
// [RULE15] First written byte is register pointer
// [RULE16] Receiver pulls data low on ninth clock
// [RULE17] Device acks writes, master acks reads
// [RULE18] Read uses pointer write then restart
// [RULE19] Snapshot pins, release alert at read ack
// [RULE20] Read group flags cleared, new reference
// [RULE21] Changes during shift-out raise alert again
// [RULE22] Writing outputs never raises alert itself
// [RULE23] Pointers 0-7 select eight registers
// [RULE24] Output defaults from address selects, nibble-wise
// [RULE25] Foreign addresses are neither acked nor used
`timescale 1ns/100ps
`default_nettype none
`include "iex_map.vh"

module iex_expander (
  input wire mclk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire bus_abort_n,
  input wire addr_select_low,
  input wire addr_select_high,
  input wire [7:0] drain_port_group_in,
  output reg [7:0] drain_port_group_out,
  output reg [7:0] drain_port_group_oe_n,
  input wire [7:0] pushpull_port_group_in,
  output reg [7:0] pushpull_port_group_out,
  output reg [7:0] pushpull_port_group_oe_n,
  output reg change_alert_n
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_RD = 3'h4;
  localparam ST_IGNORE = 3'h5;

  // Two-flop synchronisers; the first stage feeds only the second.
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [1:0] abort_sync_reg;
  reg [1:0] sel_low_sync_reg;
  reg [1:0] sel_high_sync_reg;
  reg [7:0] drain_meta_reg;
  reg [7:0] drain_pin_reg;
  reg [7:0] pp_meta_reg;
  reg [7:0] pp_pin_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;

  always @(posedge mclk) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      abort_sync_reg <= 2'h3;
      sel_low_sync_reg <= 2'h0;
      sel_high_sync_reg <= 2'h0;
      drain_meta_reg <= 8'hFF;
      drain_pin_reg <= 8'hFF;
      pp_meta_reg <= 8'hFF;
      pp_pin_reg <= 8'hFF;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      abort_sync_reg <= {abort_sync_reg[0], bus_abort_n};
      sel_low_sync_reg <= {sel_low_sync_reg[0], addr_select_low};
      sel_high_sync_reg <= {sel_high_sync_reg[0], addr_select_high};
      drain_meta_reg <= drain_port_group_in;
      drain_pin_reg <= drain_meta_reg;
      pp_meta_reg <= pushpull_port_group_in;
      pp_pin_reg <= pp_meta_reg;
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire abort = ~abort_sync_reg[1];
  wire scl_rise = scl & ~scl_prev_reg;
  wire scl_fall = ~scl & scl_prev_reg;
  // [RULE10] Start detection.
  wire start_seen = scl & scl_prev_reg & sda_prev_reg & ~sda;
  // [RULE11] Stop detection.
  wire stop_seen = scl & scl_prev_reg & ~sda_prev_reg & sda;

  // Register file: index 0 is group A (drain), index 1 is group B (push-pull).
  reg [7:0] out_reg [0:1];
  reg [7:0] dir_reg [0:1];
  reg [7:0] mask_reg [0:1];
  reg [7:0] ref_reg [0:1];
  reg [1:0] flag_reg;
  reg [1:0] strap_cnt_reg;

  // Serial engine state.
  reg [2:0] state_reg;
  reg in_ack_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [2:0] ptr_reg;
  reg master_nack_reg;
  reg sda_low_reg;
  reg snap_pulse_reg;

  assign sda_out = 1'h0;
  assign sda_oe_n = ~sda_low_reg;

  wire [7:0] pins0 = drain_pin_reg;
  wire [7:0] pins1 = pp_pin_reg;

  // [RULE23] Read-back value of the selected register.
  function [7:0] rd_byte;
    input [2:0] ptr;
    begin
      case (ptr)
        `IEX_CMD_IN_A: rd_byte = pins0;
        `IEX_CMD_IN_B: rd_byte = pins1;
        `IEX_CMD_OUT_A: rd_byte = out_reg[0];
        `IEX_CMD_OUT_B: rd_byte = out_reg[1];
        `IEX_CMD_DIR_A: rd_byte = dir_reg[0];
        `IEX_CMD_DIR_B: rd_byte = dir_reg[1];
        `IEX_CMD_MASK_A: rd_byte = mask_reg[0];
        default: rd_byte = mask_reg[1];
      endcase
    end
  endfunction

  // Value of the selected register, as loaded into the shifter.
  wire [7:0] rd_now = rd_byte(ptr_reg);

  // [RULE14] Own address match.
  wire [6:0] own_addr = {`IEX_ADDR_FIXED, sel_high_sync_reg[1], sel_low_sync_reg[1]};
  wire addr_match = (shift_reg[7:1] == own_addr);
  wire byte_done = (bit_cnt_reg == `IEX_BYTE_BITS);
  wire strap_done = (strap_cnt_reg == `IEX_STRAP_DONE);

  // [RULE1] Abort and stop dominate the engine; flags live in a separate process.
  always @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      in_ack_reg <= 1'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      ptr_reg <= 3'h0;
      master_nack_reg <= 1'h0;
      sda_low_reg <= 1'h0;
      snap_pulse_reg <= 1'h0;
      out_reg[0] <= 8'h00;
      out_reg[1] <= 8'h00;
      dir_reg[0] <= `IEX_DIR_RESET;
      dir_reg[1] <= `IEX_DIR_RESET;
      mask_reg[0] <= `IEX_MASK_RESET;
      mask_reg[1] <= `IEX_MASK_RESET;
    end else begin
      snap_pulse_reg <= 1'h0;
      // [RULE24] Strap-selected output defaults.
      if (strap_cnt_reg == `IEX_STRAP_LOAD) begin
        out_reg[0] <= {{4{sel_high_sync_reg[1]}}, {4{sel_low_sync_reg[1]}}};
        out_reg[1] <= {{4{sel_high_sync_reg[1]}}, {4{sel_low_sync_reg[1]}}};
      end
      if (abort | stop_seen) begin
        state_reg <= ST_IDLE;
        in_ack_reg <= 1'h0;
        sda_low_reg <= 1'h0;
      end else if (start_seen) begin
        state_reg <= ST_ADDR;
        in_ack_reg <= 1'h0;
        bit_cnt_reg <= 4'h0;
        sda_low_reg <= 1'h0;
      end else if (scl_rise) begin
        // [RULE12] Bits taken on the clock rise.
        if (!in_ack_reg && state_reg != ST_IDLE && state_reg != ST_IGNORE) begin
          shift_reg <= {shift_reg[6:0], sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (in_ack_reg && state_reg == ST_RD) begin
          master_nack_reg <= sda;
        end
      end else if (scl_fall) begin
        if (!in_ack_reg) begin
          if (byte_done) begin
            case (state_reg)
              ST_ADDR: begin
                // [RULE25] Foreign address is not acknowledged.
                if (addr_match) begin
                  in_ack_reg <= 1'h1;
                  // [RULE16] Device pulls data low for ack.
                  sda_low_reg <= 1'h1;
                  // [RULE19] Snapshot at read address ack.
                  if (shift_reg[0]) begin
                    tx_reg <= rd_now;
                    snap_pulse_reg <= 1'h1;
                  end
                end else begin
                  state_reg <= ST_IGNORE;
                end
              end
              ST_CMD: begin
                // [RULE15] Pointer from first written byte.
                ptr_reg <= shift_reg[2:0];
                in_ack_reg <= 1'h1;
                sda_low_reg <= 1'h1;
              end
              ST_WR: begin
                in_ack_reg <= 1'h1;
                sda_low_reg <= 1'h1;
                // [RULE23] Writable registers; input groups ignore writes.
                case (ptr_reg)
                  `IEX_CMD_OUT_A: out_reg[0] <= shift_reg;
                  `IEX_CMD_OUT_B: out_reg[1] <= shift_reg;
                  `IEX_CMD_DIR_A: dir_reg[0] <= shift_reg;
                  `IEX_CMD_DIR_B: dir_reg[1] <= shift_reg;
                  `IEX_CMD_MASK_A: mask_reg[0] <= shift_reg;
                  `IEX_CMD_MASK_B: mask_reg[1] <= shift_reg;
                  default: in_ack_reg <= 1'h1;
                endcase
              end
              ST_RD: begin
                // [RULE17] Master acks bytes the device sends.
                in_ack_reg <= 1'h1;
                sda_low_reg <= 1'h0;
              end
              default: sda_low_reg <= 1'h0;
            endcase
          end else if (state_reg == ST_RD) begin
            tx_reg <= {tx_reg[6:0], 1'h1};
            sda_low_reg <= ~tx_reg[6];
          end
        end else begin
          in_ack_reg <= 1'h0;
          bit_cnt_reg <= 4'h0;
          case (state_reg)
            ST_ADDR: begin
              // [RULE18] Read direction after restart sends data.
              if (shift_reg[0]) begin
                state_reg <= ST_RD;
                sda_low_reg <= ~tx_reg[7];
              end else begin
                state_reg <= ST_CMD;
                sda_low_reg <= 1'h0;
              end
            end
            ST_CMD: begin
              state_reg <= ST_WR;
              sda_low_reg <= 1'h0;
            end
            ST_RD: begin
              if (master_nack_reg) begin
                state_reg <= ST_IGNORE;
                sda_low_reg <= 1'h0;
              end else begin
                tx_reg <= rd_now;
                sda_low_reg <= ~rd_now[7];
              end
            end
            default: sda_low_reg <= 1'h0;
          endcase
        end
      end
    end
  end

  // Input and output register reads (pointers 0-3) rearm detection; direction and mask reads do not.
  wire snap_port = snap_pulse_reg & ~ptr_reg[2];
  wire [1:0] clr_grp = {snap_port & ptr_reg[0], snap_port & ~ptr_reg[0]};

  // [RULE3] Difference to reference on inputs.
  // [RULE5] Outputs excluded by direction.
  // [RULE7] Mask gates each port.
  wire [7:0] diff0 = (pins0 ^ ref_reg[0]) & dir_reg[0] & ~mask_reg[0];
  wire [7:0] diff1 = (pins1 ^ ref_reg[1]) & dir_reg[1] & ~mask_reg[1];
  // A group being cleared takes a fresh reference this cycle, so its old difference is void.
  wire [1:0] set_grp = {(|diff1) & strap_done & ~clr_grp[1],
    (|diff0) & strap_done & ~clr_grp[0]};

  // [RULE2] No abort term here; flags survive an abort.
  always @(posedge mclk) begin
    if (rst) begin
      strap_cnt_reg <= 2'h0;
      flag_reg <= 2'h0;
      ref_reg[0] <= 8'h00;
      ref_reg[1] <= 8'h00;
      change_alert_n <= 1'h1;
    end else begin
      if (!strap_done) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_cnt_reg == `IEX_STRAP_LOAD) begin
        ref_reg[0] <= pins0;
        ref_reg[1] <= pins1;
      end
      // [RULE20] New reference: transmitted snapshot on input reads, live pins on output reads.
      // Input reads keep the byte sent, so a change since the snapshot shows next cycle.
      if (clr_grp[0]) begin
        ref_reg[0] <= ptr_reg[1] ? pins0 : tx_reg;
      end
      if (clr_grp[1]) begin
        ref_reg[1] <= ptr_reg[1] ? pins1 : tx_reg;
      end
      // [RULE6] Per-group flags; clear beats set.
      // [RULE21] Later changes set the flag again.
      flag_reg <= (flag_reg & ~clr_grp) | set_grp;
      // [RULE4] Latched alert, low while pending.
      change_alert_n <= ~(|((flag_reg & ~clr_grp) | set_grp));
    end
  end

  // [RULE8] Direction drives the pin enables.
  // [RULE22] Output writes only touch drivers, never flags.
  always @(posedge mclk) begin
    if (rst) begin
      drain_port_group_out <= 8'h00;
      drain_port_group_oe_n <= 8'hFF;
      pushpull_port_group_out <= 8'h00;
      pushpull_port_group_oe_n <= 8'hFF;
    end else begin
      drain_port_group_out <= 8'h00;
      drain_port_group_oe_n <= dir_reg[0] | out_reg[0];
      pushpull_port_group_out <= out_reg[1];
      pushpull_port_group_oe_n <= dir_reg[1];
    end
  end

endmodule // iex_expander
`default_nettype wire

/* File: pkg/iex_map.vh */
// Constants for the sixteen-port expander: bus address, command codes, reset values.
// Included by the expander design; holds definitions only.
`ifndef IEX_MAP_VH
`define IEX_MAP_VH

// Fixed upper five bits of the seven-bit slave address.
`define IEX_ADDR_FIXED 5'h16

// Command byte register pointers; bit 0 picks group A (drain) or B (push-pull).
`define IEX_CMD_IN_A 3'h0
`define IEX_CMD_IN_B 3'h1
`define IEX_CMD_OUT_A 3'h2
`define IEX_CMD_OUT_B 3'h3
`define IEX_CMD_DIR_A 3'h4
`define IEX_CMD_DIR_B 3'h5
`define IEX_CMD_MASK_A 3'h6
`define IEX_CMD_MASK_B 3'h7

// Reset values of direction and mask registers.
`define IEX_DIR_RESET 8'h00
`define IEX_MASK_RESET 8'h00

// Bits per byte on the serial bus.
`define IEX_BYTE_BITS 4'h8

// Strap counter: value at which address selects are taken, and value when done.
`define IEX_STRAP_LOAD 2'h2
`define IEX_STRAP_DONE 2'h3

`endif

/* File: sim/iex_expander_monitor.sv */
// Checker for the expander: bus acknowledge, abort and alert timing at the ports.
// Sees only the top module's ports; bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module iex_mon (
  input wire mclk,
  input wire rst,
  input wire scl_in,
  input wire sda_oe_n,
  input wire bus_abort_n,
  input wire addr_select_low,
  input wire addr_select_high,
  input wire [7:0] drain_port_group_in,
  input wire [7:0] pushpull_port_group_in,
  input wire [7:0] pushpull_port_group_out,
  input wire change_alert_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_abort_idle; !bus_abort_n [*5] |-> sda_oe_n; endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("bus held in abort");
  property p_abort_keep; $rose(change_alert_n) |-> $past(bus_abort_n, 6); endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("alert cleared by abort");
  property p_alert_cause; $fell(change_alert_n) |-> $past(drain_port_group_in, 6) !=
    $past(drain_port_group_in, 1) || $past(pushpull_port_group_in, 6) !=
    $past(pushpull_port_group_in, 1); endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without pin change");
  property p_alert_latch; $fell(change_alert_n) |=> !change_alert_n [*8]; endproperty
  a_alert_latch: assert property (p_alert_latch) else $error("alert not latched");
  property p_alert_clear; $rose(change_alert_n) |-> ##[1:8] !sda_oe_n; endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("alert freed off ack");
  property p_sda_low; $changed(sda_oe_n) && bus_abort_n && $past(bus_abort_n, 5) |-> !scl_in;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved, clock high");
  property p_ack_hold; $rose(scl_in) && !sda_oe_n && bus_abort_n |=> !sda_oe_n [*6]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low not held");
  property p_defaults; $fell(rst) |-> ##6 pushpull_port_group_out ==
    {{4{addr_select_high}}, {4{addr_select_low}}}; endproperty
  a_defaults: assert property (p_defaults) else $error("bad output default");
  c_alert: cover property ($fell(change_alert_n));
  c_clear: cover property ($rose(change_alert_n));
  c_ack: cover property ($fell(sda_oe_n));
endmodule // iex_mon
bind iex_expander iex_mon u_mon (.mclk, .rst, .scl_in, .sda_oe_n, .bus_abort_n,
  .addr_select_low, .addr_select_high, .drain_port_group_in, .pushpull_port_group_in,
  .pushpull_port_group_out, .change_alert_n);
`default_nettype wire

/* File: sim/iex_master.sv */
// Bus master model: start, stop, byte write and byte read at a 125 ns bus clock.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module iex_master (
  input wire sda,
  output logic scl,
  output logic sda_m
);
  localparam realtime Q = 31.25;
  // Longer clock low phases make a slow master.
  realtime lo_extra = 0.0;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #(Q + lo_extra);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // iex_master
`default_nettype wire

/* File: sim/iex_expander_tb.sv */
// Testbench for the expander: registers over the two-wire bus, alert and abort.
// Assumes the design, the bus master model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "iex_map.vh"
module iex_expander_tb;
  localparam logic [6:0] DEV = {`IEX_ADDR_FIXED, 2'b10};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic bus_abort_n = 1'b1;
  logic [7:0] pin_a = 8'hA5;
  logic [7:0] pin_b = 8'h3C;
  logic [7:0] rd_v;
  logic ak;
  int err_total = 0;
  int tests_run = 0;
  wire scl;
  wire sda_m;
  wire sda_oe_n;
  wire alert_n;
  wire [7:0] oe_a;
  wire [7:0] out_a;
  wire sda_o;
  wire [7:0] out_b;
  wire [7:0] oe_b;
  wire sda = sda_m & (sda_oe_n | sda_o);
  initial forever #5 mclk = ~mclk;
  iex_expander i_iex_expander (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n(sda_oe_n), .bus_abort_n(bus_abort_n), .addr_select_low(1'b0),
    .addr_select_high(1'b1), .drain_port_group_in(pin_a), .drain_port_group_out(out_a),
    .drain_port_group_oe_n(oe_a), .pushpull_port_group_in(pin_b),
    .pushpull_port_group_out(out_b), .pushpull_port_group_oe_n(oe_b), .change_alert_n(alert_n));
  iex_master bm (.sda(sda), .scl(scl), .sda_m(sda_m));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d bad %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic rw, input logic [2:0] cmd, input logic [7:0] d);
    @(posedge mclk);
    #2.7;
    bm.start();
    bm.wbyte({DEV, 1'b0}, ak);
    chk({7'h0, ak}, 8'h01);
    bm.wbyte({5'h0, cmd}, ak);
    if (rw) begin
      bm.start();
      bm.wbyte({DEV, 1'b1}, ak);
      bm.rbyte(1'b1, rd_v);
      chk(rd_v, d);
    end else begin
      bm.wbyte(d, ak);
      chk({7'h0, ak}, 8'h01);
    end
    bm.stop();
  endtask
  task automatic alert_is(input logic v);
    int n;
    n = 0;
    while (alert_n !== v && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, alert_n}, {7'h0, v});
    if (n == 40) print_verdict();
  endtask
  task automatic pins(input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    pin_a <= a;
    pin_b <= b;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (12) @(posedge mclk);
    #2.7;
    for (int c = 2; c < 8; c++) xfer(1'b1, c[2:0], c < 4 ? 8'hF0 : 8'h00);
    chk(oe_a, 8'hF0);
    bm.start();
    bm.wbyte({`IEX_ADDR_FIXED, 2'b01, 1'b0}, ak);
    bm.stop();
    chk({7'h0, ak}, 8'h00);
    $display("test defaults done");
    xfer(1'b0, 3'h6, 8'hFF);
    xfer(1'b0, 3'h4, 8'hFF);
    xfer(1'b0, 3'h6, 8'h00);
    bm.lo_extra = 500.0;
    xfer(1'b0, 3'h5, 8'h0F);
    bm.lo_extra = 0.0;
    xfer(1'b0, 3'h3, 8'h5A);
    xfer(1'b1, 3'h3, 8'h5A);
    xfer(1'b0, 3'h2, 8'h3C);
    xfer(1'b1, 3'h2, 8'h3C);
    xfer(1'b0, 3'h0, 8'h00);
    xfer(1'b1, 3'h0, 8'hA5);
    chk(oe_a, 8'hFF);
    chk(out_a, 8'h00);
    chk(oe_b, 8'h0F);
    chk(out_b, 8'h5A);
    chk({7'h0, alert_n}, 8'h01);
    $display("test config done");
    pins(8'hA5, 8'h2C);
    repeat (12) @(posedge mclk);
    chk({7'h0, alert_n}, 8'h01);
    pins(8'hA5, 8'h2D);
    alert_is(1'b0);
    pins(8'hA4, 8'h2D);
    xfer(1'b1, 3'h1, 8'h2D);
    chk({7'h0, alert_n}, 8'h00);
    xfer(1'b1, 3'h0, 8'hA4);
    alert_is(1'b1);
    xfer(1'b0, 3'h6, 8'h01);
    pins(8'hA5, 8'h2D);
    repeat (12) @(posedge mclk);
    chk({7'h0, alert_n}, 8'h01);
    pins(8'hA7, 8'h2D);
    alert_is(1'b0);
    $display("test alert done");
    #2.7;
    bm.start();
    @(posedge mclk);
    bus_abort_n <= 1'b0;
    repeat (60) @(posedge mclk);
    bus_abort_n <= 1'b1;
    repeat (110) @(posedge mclk);
    #2.7;
    bm.wbyte({DEV, 1'b0}, ak);
    bm.stop();
    chk({7'h0, ak}, 8'h00);
    chk({7'h0, alert_n}, 8'h00);
    $display("test abort done");
    fork
      xfer(1'b1, 3'h0, 8'hA7);
      begin
        #3800;
        pins(8'hA5, 8'h2D);
      end
    join
    alert_is(1'b0);
    $display("test shift done");
    print_verdict();
  end
endmodule // iex_expander_tb
`default_nettype wire
